// ==== design/tssc_defines.vh ====
// Purpose: constants for the timer source and stop control block
// Assumes: registers reached over a plain strobe port, 8-bit data
// Notes:   all offsets and field positions live here
// Notes on behaviour
// - timer1 bit0 low counts sysclk/16
// - timer1 bit5 picks sysclk/4096 or pin
// - timer2 bit1 high routes external pin
// - timer2 bit4 picks sysclk/16 or timer1 overflow
// - ctrl_a bits 2,3 halt timers 1,2
// - ctrl_b bits 2,3,5,6 halt timers 3-6
// - timer5 bit6 picks timer2 or timer4 overflow
// - timer5 ctrl_b bit7 low counts sysclk/16
// - timer6 bit7 picks sysclk/16 or timer5 overflow
// - timer4 two-bit source field, four codes
`ifndef TSSC_DEFINES_VH
`define TSSC_DEFINES_VH

// ********************************************
// register map
// ********************************************
`define TSSC_ADDR_W      16
`define TSSC_CTRL_A_ADDR 16'h00f4
`define TSSC_CTRL_B_ADDR 16'h00f5
`define TSSC_RESET_VAL   8'h00

// ********************************************
// ctrl_a fields
// ********************************************
`define TSSC_A_T1_SEL_A  0
`define TSSC_A_T2_SEL_A  1
`define TSSC_A_T1_HALT   2
`define TSSC_A_T2_HALT   3
`define TSSC_A_T2_SEL_B  4
`define TSSC_A_T1_SEL_B  5
`define TSSC_A_T5_SEL_B  6
`define TSSC_A_T6_SEL    7

// ********************************************
// ctrl_b fields
// ********************************************
`define TSSC_B_T3_SEL    0
`define TSSC_B_T4_SEL_LO 1
`define TSSC_B_T3_HALT   2
`define TSSC_B_T4_HALT   3
`define TSSC_B_T4_SEL_HI 4
`define TSSC_B_T5_HALT   5
`define TSSC_B_T6_HALT   6
`define TSSC_B_T5_SEL_A  7

// ********************************************
// prescaler taps and timer 4 codes
// ********************************************
`define TSSC_PRE_W       12
`define TSSC_DIV2_BIT    0
`define TSSC_DIV16_BIT   3
`define TSSC_DIV4096_BIT 11
`define TSSC_T4_T3OVF    2'b00
`define TSSC_T4_DIV16    2'b01
`define TSSC_T4_DIV2     2'b10
`define TSSC_T4_SUBOSC   2'b11

`endif

// ==== design/tssc_timer.v ====
// Purpose: one 8-bit down-counting timer with reload and overflow pulse
// Assumes: count tick is a one-cycle pulse in the clk domain
// Notes:   reload value comes from a port; counter itself not mapped
`timescale 1ns/1ns
`default_nettype none

module tssc_timer #(
    parameter W = 8
) (
    input  wire         clk,
    input  wire         rst,
    input  wire         tick,
    input  wire         halt,
    input  wire [W-1:0] reload,
    output reg          ovf_q
);

    reg [W-1:0] cnt_q;

    // ********************************************
    // counter
    // ********************************************
    // wrap from zero reloads and raises overflow for one cycle
    always @(posedge clk) begin
        if (rst) begin
            cnt_q <= {W{1'b1}};
            ovf_q <= 1'b0;
        end else begin
            ovf_q <= 1'b0;
            if (tick && !halt) begin
                if (cnt_q == {W{1'b0}}) begin
                    cnt_q <= reload;
                    ovf_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule // tssc_timer

`default_nettype wire

// ==== design/tssc_top.v ====
// Purpose: count source selection and run/stop control for six timers
//          behind two 8-bit mode registers
// Assumes: all inputs synchronous to clk; oscillator ticks are one-cycle
//          pulses; the external pin is a level sampled every clock
// Notes:   timer 3 source chosen elsewhere, arrives as a tick input
//          timer counts are not mapped; reload values come from a port
//          overflow outputs trail the internal chain by one clock
//          halting a timer leaves the shared prescaler running
`timescale 1ns/1ns
`default_nettype none
`include "tssc_defines.vh"

module tssc_top #(
    parameter TW = 8
) (
    input  wire                    clk,
    input  wire                    rst,
    input  wire [`TSSC_ADDR_W-1:0] addr,
    input  wire [7:0]              wdata,
    input  wire                    wr,
    input  wire                    rd,
    output reg  [7:0]              rdata_q,
    input  wire                    main_osc_tick,
    input  wire                    sub_osc_tick,
    input  wire                    sys_clk_sel_sub,
    input  wire                    external_timer_clock_pin,
    input  wire                    timer3_source_tick,
    input  wire [6*TW-1:0]         reload_values,
    output reg  [5:0]              timer_ovf_q,
    output reg  [5:0]              timer_run_q
);

    reg  [7:0]             ctrl_a_q;
    reg  [7:0]             ctrl_b_q;
    reg  [`TSSC_PRE_W-1:0] pre_q;
    reg  [`TSSC_PRE_W-1:0] pre_prev_q;
    reg                    pin_q;
    reg                    t1_tick;
    reg                    t2_tick;
    reg                    t4_tick;
    reg                    t5_tick;
    reg                    t6_tick;
    wire [5:0]             tick;
    wire [1:0]             t4_code;
    wire                   t1_alt;
    wire                   t2_alt;
    wire                   t3_tick;
    wire                   t5_chain;
    wire                   sys_tick;
    wire [`TSSC_PRE_W-1:0] fall;
    wire                   div2;
    wire                   div16;
    wire                   div4096;
    wire                   pin_rise;
    wire [5:0]             halt;
    wire [5:0]             ovf;
    wire                   timer1_source_sel_a;
    wire                   timer2_source_sel_a;
    wire                   timer1_halt;
    wire                   timer2_halt;
    wire                   timer2_source_sel_b;
    wire                   timer1_source_sel_b;
    wire                   timer5_source_sel_b;
    wire                   timer6_source_sel;
    wire                   timer4_source_sel_low;
    wire                   timer3_halt;
    wire                   timer4_halt;
    wire                   timer4_source_sel_high;
    wire                   timer5_halt;
    wire                   timer6_halt;
    wire                   timer5_source_sel_a;

    // ********************************************
    // register port
    // ********************************************
    // writes store; reads answer the next cycle, unmapped read as zero
    // the full 16-bit address is decoded, so there are no alias slots
    // read data drop back to zero after one cycle to ease bus muxing
    always @(posedge clk) begin
        if (rst) begin
            ctrl_a_q <= `TSSC_RESET_VAL;
            ctrl_b_q <= `TSSC_RESET_VAL;
            rdata_q  <= 8'h00;
        end else begin
            if (wr && addr == `TSSC_CTRL_A_ADDR)
                ctrl_a_q <= wdata;
            if (wr && addr == `TSSC_CTRL_B_ADDR)
                ctrl_b_q <= wdata;
            if (rd && addr == `TSSC_CTRL_A_ADDR)
                rdata_q <= ctrl_a_q;
            else if (rd && addr == `TSSC_CTRL_B_ADDR)
                rdata_q <= ctrl_b_q;
            else
                rdata_q <= 8'h00;
        end
    end

    // ********************************************
    // prescaler
    // ********************************************
    // follows whichever oscillator drives the system clock
    assign sys_tick = sys_clk_sel_sub ? sub_osc_tick
                                      : main_osc_tick;

    // ripple count; each tap falls once per 2^(n+1) system ticks
    // switching oscillators keeps the count, so the first divided pulse
    // after a switch may come early
    always @(posedge clk) begin
        if (rst) begin
            pre_q      <= {`TSSC_PRE_W{1'b0}};
            pre_prev_q <= {`TSSC_PRE_W{1'b0}};
        end else begin
            if (sys_tick)
                pre_q <= pre_q + {{(`TSSC_PRE_W-1){1'b0}}, 1'b1};
            pre_prev_q <= pre_q;
        end
    end

    // a falling tap is one clock wide, whatever the tick rate
    assign fall    = pre_prev_q & ~pre_q;
    assign div2    = fall[`TSSC_DIV2_BIT];
    assign div16   = fall[`TSSC_DIV16_BIT];
    assign div4096 = fall[`TSSC_DIV4096_BIT];

    // ********************************************
    // external clock pin
    // ********************************************
    // one count per rising edge; a level held high counts once only
    // the sampler clears on reset, so a pin already high then counts once
    always @(posedge clk) begin
        if (rst)
            pin_q <= 1'b0;
        else
            pin_q <= external_timer_clock_pin;
    end

    assign pin_rise = external_timer_clock_pin & ~pin_q;

    // ********************************************
    // control fields
    // ********************************************
    // named taps on the two mode registers; the logic below reads
    // these rather than raw bit positions
    assign timer1_source_sel_a    = ctrl_a_q[`TSSC_A_T1_SEL_A];
    assign timer2_source_sel_a    = ctrl_a_q[`TSSC_A_T2_SEL_A];
    assign timer1_halt            = ctrl_a_q[`TSSC_A_T1_HALT];
    assign timer2_halt            = ctrl_a_q[`TSSC_A_T2_HALT];
    assign timer2_source_sel_b    = ctrl_a_q[`TSSC_A_T2_SEL_B];
    assign timer1_source_sel_b    = ctrl_a_q[`TSSC_A_T1_SEL_B];
    assign timer5_source_sel_b    = ctrl_a_q[`TSSC_A_T5_SEL_B];
    assign timer6_source_sel      = ctrl_a_q[`TSSC_A_T6_SEL];

    // bit 0 of ctrl_b steers timer 3 outside this block; it is only
    // stored and read back here
    assign timer4_source_sel_low  = ctrl_b_q[`TSSC_B_T4_SEL_LO];
    assign timer3_halt            = ctrl_b_q[`TSSC_B_T3_HALT];
    assign timer4_halt            = ctrl_b_q[`TSSC_B_T4_HALT];
    assign timer4_source_sel_high = ctrl_b_q[`TSSC_B_T4_SEL_HI];
    assign timer5_halt            = ctrl_b_q[`TSSC_B_T5_HALT];
    assign timer6_halt            = ctrl_b_q[`TSSC_B_T6_HALT];
    assign timer5_source_sel_a    = ctrl_b_q[`TSSC_B_T5_SEL_A];

    // ********************************************
    // timer 1 source
    // ********************************************
    // second-level choice first, so the outer mux stays a plain 2:1
    assign t1_alt = timer1_source_sel_b ? pin_rise
                                        : div4096;

    // /4096 and pin paths only when the first select bit is set
    always @* begin
        if (!timer1_source_sel_a)
            t1_tick = div16;
        else
            t1_tick = t1_alt;
    end

    // ********************************************
    // timer 2 source
    // ********************************************
    // chained, it takes the timer 1 pulse in the cycle it is raised,
    // so timer 2 steps one clock behind timer 1
    assign t2_alt = timer2_source_sel_b ? ovf[0]
                                        : div16;

    // the pin outranks the second select bit
    always @* begin
        if (timer2_source_sel_a)
            t2_tick = pin_rise;
        else
            t2_tick = t2_alt;
    end

    // ********************************************
    // timer 3 source
    // ********************************************
    // chosen outside this block and passed in as a tick; only its halt
    // bit and its overflow towards timer 4 are handled here
    assign t3_tick = timer3_source_tick;

    // ********************************************
    // timer 4 source
    // ********************************************
    // high bit of the code sits at bit 4, low bit at bit 1
    assign t4_code = {timer4_source_sel_high, timer4_source_sel_low};

    // the sub oscillator code bypasses the prescaler, so it keeps its
    // rate whichever oscillator drives the system clock
    always @* begin
        case (t4_code)
            `TSSC_T4_T3OVF:  t4_tick = ovf[2];
            `TSSC_T4_DIV16:  t4_tick = div16;
            `TSSC_T4_DIV2:   t4_tick = div2;
            `TSSC_T4_SUBOSC: t4_tick = sub_osc_tick;
            default:         t4_tick = 1'b0;
        endcase
    end

    // ********************************************
    // timer 5 source
    // ********************************************
    // the chain choice lives in ctrl_a and its enable in ctrl_b;
    // software sets both before timer 5 follows another timer
    assign t5_chain = timer5_source_sel_b ? ovf[3]
                                          : ovf[1];

    // prescaled clock unless the first select bit is set
    always @* begin
        if (!timer5_source_sel_a)
            t5_tick = div16;
        else
            t5_tick = t5_chain;
    end

    // ********************************************
    // timer 6 source
    // ********************************************
    // timer 6 may end a four-deep chain (1, 2, 5, 6 or 3, 4, 5, 6); each link adds one clock
    // of latency because overflow leaves every timer from a flop
    always @* begin
        if (timer6_source_sel)
            t6_tick = ovf[4];
        else
            t6_tick = div16;
    end

    // ********************************************
    // tick gather
    // ********************************************
    // per-timer ticks in timer order, bit n-1 for timer n
    assign tick = {t6_tick, t5_tick, t4_tick,
                   t3_tick, t2_tick, t1_tick};

    // ********************************************
    // halt bits
    // ********************************************
    // a halted timer holds its count; the prescaler keeps running, so
    // a restart picks up the divided clocks in their usual phase
    assign halt = {timer6_halt,
                   timer5_halt,
                   timer4_halt,
                   timer3_halt,
                   timer2_halt,
                   timer1_halt};

    // ********************************************
    // timers
    // ********************************************
    // one counter per timer; counts are not mapped, only overflow leaves
    // the reload slice for timer n sits at bits (n-1)*TW and up
    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_tmr
            tssc_timer #(.W(TW)) u_tmr (
                .clk    (clk),
                .rst    (rst),
                .tick   (tick[g]),
                .halt   (halt[g]),
                .reload (reload_values[g*TW +: TW]),
                .ovf_q  (ovf[g])
            );
        end
    endgenerate

    // ********************************************
    // status outputs
    // ********************************************
    // ovf from the timers is already a flop; a copy keeps outputs registered
    // the copy costs one clock, so outputs trail the internal chain
    // run bits show the halt state of the previous cycle
    always @(posedge clk) begin
        if (rst) begin
            timer_ovf_q <= 6'b000000;
            timer_run_q <= 6'b000000;
        end else begin
            timer_ovf_q <= ovf;
            timer_run_q <= ~halt;
        end
    end

endmodule // tssc_top

`default_nettype wire

// ==== tb/tssc_chk_asserts.sv ====
// Purpose: assertions on register access and timer run/overflow ports
// Assumes: shadow copies of both control registers track every write
// Notes:   overflow checks watch timers 1, 2 and 6
`timescale 1ns/1ns
`default_nettype none
module tssc_chk (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [15:0] addr,
    input wire logic [7:0]  wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [7:0]  rdata_q,
    input wire logic [5:0]  timer_ovf_q,
    input wire logic [5:0]  timer_run_q
);
    logic [7:0] a_q;
    logic [7:0] b_q;
    logic [5:0] halt_w;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // shadows; unmapped writes are dropped as in the block
    always_ff @(posedge clk) begin
        if (rst) begin
            a_q <= 8'h00;
            b_q <= 8'h00;
        end else if (wr) begin
            if (addr == 16'h00f4) a_q <= wdata;
            if (addr == 16'h00f5) b_q <= wdata;
        end
    end
    assign halt_w = {b_q[6], b_q[5], b_q[3], b_q[2], a_q[3], a_q[2]};
    // ****************
    // properties
    // ****************
    run_bits_a: assert property (
        !$past(rst) |-> timer_run_q == ~$past(halt_w))
        else $error("run bits differ from halt bits");
    read_a_a: assert property (
        rd && addr == 16'h00f4 |=> rdata_q == $past(a_q))
        else $error("ctrl a read wrong");
    read_b_a: assert property (
        rd && addr == 16'h00f5 |=> rdata_q == $past(b_q))
        else $error("ctrl b read wrong");
    read_idle_a: assert property (
        !rd |=> rdata_q == 8'h00)
        else $error("read data not cleared");
    read_unmap_a: assert property (
        rd && addr != 16'h00f4 && addr != 16'h00f5 |=> rdata_q == 8'h00)
        else $error("unmapped read not zero");
    ovf_pulse_a: assert property (
        timer_ovf_q[0] |=> !timer_ovf_q[0])
        else $error("overflow longer than one cycle");
    halt_one_a: assert property (
        timer_ovf_q[0] |-> $past(timer_run_q[0]))
        else $error("halted timer 1 overflowed");
    halt_six_a: assert property (
        timer_ovf_q[5] |-> $past(timer_run_q[5]))
        else $error("halted timer 6 overflowed");
    chain_two_a: assert property (
        $past(a_q[4], 2) && !$past(a_q[1], 2) && timer_ovf_q[1]
        |-> $past(timer_ovf_q[0]))
        else $error("chained timer 2 out of step");
    cover property (rd && addr == 16'h00f5);
    cover property (timer_ovf_q[1] && a_q[4]);
    cover property (timer_run_q == 6'h00);
endmodule // tssc_chk
bind tssc_top tssc_chk tssc_chk_inst (.clk(clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
    .timer_ovf_q(timer_ovf_q), .timer_run_q(timer_run_q));
`default_nettype wire

// ==== tb/tssc_top_bench.sv ====
// Purpose: bench for source selection and halt control of six timers
// Assumes: main tick every cycle, all reload values zero
// Notes:   source checked by the gap between overflow pulses
`timescale 1ns/1ns
`default_nettype none
module tssc_top_bench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        sub = 1'b0;
    logic        pin = 1'b0;
    logic        sel_sub = 1'b0;
    logic [3:0]  ph = 4'h0;
    logic [1:0]  s3 = 2'h0;
    wire  [7:0]  rdata_q;
    wire  [5:0]  ovf;
    wire  [5:0]  run;
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          idx[5] = '{0, 1, 3, 4, 5};
    // ctrl a, ctrl b, sub clock, gaps of timers 1,2,4,5,6
    int tab[5][8] = '{'{8'h00, 8'h00, 0, 16, 16, 3, 16, 16},
        '{8'ha3, 8'h82, 0, 10, 10, 16, 10, 10},
        '{8'hd1, 8'h90, 0, 4096, 4096, 2, 2, 2},
        '{8'h40, 8'h92, 0, 16, 16, 3, 3, 16},
        '{8'h00, 8'h00, 1, 48, 48, 3, 48, 48}};
    always #25 clk = ~clk;
    tssc_top tssc_top_inst (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata_q(rdata_q), .main_osc_tick(1'b1),
        .sub_osc_tick(sub), .sys_clk_sel_sub(sel_sub),
        .external_timer_clock_pin(pin), .timer3_source_tick(sub),
        .reload_values(48'h0), .timer_ovf_q(ovf), .timer_run_q(run));
    // pin rises every 10 cycles, sub tick every 3rd; hang guard
    always @(posedge clk) begin
        ph <= (ph == 4'h9) ? 4'h0 : ph + 4'h1;
        pin <= ph < 4'h5;
        s3 <= (s3 == 2'h2) ? 2'h0 : s3 + 2'h1;
        sub <= s3 == 2'h0;
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_mismatch++;
            test_done;
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(16'(rdata_q), 16'(e));
    endtask
    // skip a possibly stale pulse, then time one full period
    task automatic gap(input int i, input int e);
        int n;
        repeat (2) begin
            @(negedge clk);
            while (ovf[i] !== 1'b1) @(negedge clk);
        end
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (ovf[i] !== 1'b1);
        chk(16'(n), 16'(e));
    endtask
    task automatic test_done;
        $display("compares %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        wreg(16'h00f6, 8'h5a);
        rchk(16'h00f6, 8'h00);
        rchk(16'h00f4, 8'h00);
        rchk(16'h00f5, 8'h00);
        chk(16'(run), 16'h003f);
        $display("register test done");
        foreach (tab[k]) begin
            @(posedge clk);
            sel_sub <= tab[k][2][0];
            wreg(16'h00f4, tab[k][0][7:0]);
            wreg(16'h00f5, tab[k][1][7:0]);
            rchk(16'h00f4, tab[k][0][7:0]);
            rchk(16'h00f5, tab[k][1][7:0]);
            for (int j = 0; j < 5; j++)
                gap(idx[j], tab[k][j+3]);
            $display("source test %0d done", k);
        end
        // halt all while timers 3 and 4 overflow every 3 cycles and the rest every 48
        wreg(16'h00f4, 8'h0c);
        wreg(16'h00f5, 8'h6c);
        repeat (3) @(negedge clk);
        chk(16'(run), 16'h0000);
        repeat (150) @(negedge clk) chk(16'(ovf), 16'h0000);
        wreg(16'h00f4, 8'h00);
        wreg(16'h00f5, 8'h00);
        gap(0, 48);
        $display("halt test done");
        test_done;
    end
endmodule // tssc_top_bench
`default_nettype wire
